// ==== pmm_pkg.sv ====
// package of constants for the pluggable module management block
// Functional notes
// - seven low-speed control lines
// - answer serial bus only while selected
// - host reads and writes memory map
// - long reset pulse restores all defaults
// - completion: interrupt plus not-ready flag cleared
// - power-up raises completion interrupt unasked
// - low-power input limits module power
// - module pulls presence line low
// - interrupt low flags fault or status
// - interrupt is open-collector, host pulls up
// - channels addressable and individually disabled
package pmm_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int RST_MIN_NS = 10_000;
    localparam int INIT_NS = 1_000;
    localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999)
        / 1000;
    localparam int INIT_CYC = (INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // ----------------------------------------------------------------
    // serial bus and memory map
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [2:0] IDX_STATUS = 3'h0;
    localparam logic [2:0] IDX_FLAGS = 3'h1;
    localparam logic [2:0] IDX_CHAN = 3'h2;
    localparam logic [2:0] IDX_FAULT = 3'h3;
    localparam int ST_DNR_BIT = 0;
    localparam int ST_LP_BIT = 1;
    localparam int FL_DONE_BIT = 0;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_PTR = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    // ----------------------------------------------------------------
    // synchroniser lanes and their idle values
    // ----------------------------------------------------------------
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_LP = 3;
    localparam int PIN_RST = 4;
    localparam int PIN_TOG = 5;
    localparam logic [5:0] PIN_IDLE = 6'h17;
    typedef enum logic [2:0] {
        MD_INIT = 3'h1, MD_RST = 3'h2, MD_RUN = 3'h4
    } pmm_mode_t;
    typedef enum logic [4:0] {
        PS_IDLE = 5'h01, PS_RX = 5'h02, PS_ACK = 5'h04,
        PS_TX = 5'h08, PS_HACK = 5'h10
    } pmm_ps_t;
endpackage

// ==== pmm_ctrl.sv ====
// management and control logic of a four-lane pluggable module
`timescale 1ns/1ps
module pmm_ctrl
    import pmm_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic serial_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    output logic module_present_n_out,
    output logic module_present_n_oe,
    output logic interrupt_n_out,
    output logic interrupt_n_oe,
    input wire logic [3:0] chan_fault,
    output logic [3:0] tx_disable,
    output logic power_limit
);
    // every property runs on the core clock and rests during reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // link domain: sample sda on each serial clock rise
    // ----------------------------------------------------------------
    // the serial clock stops between frames, so nothing here needs reset;
    // the toggle start value only seeds the core side's comparison
    logic lk_bit_q;
    logic lk_tog_q = 1'b0;
    logic lk_bit_d;
    logic lk_tog_d;
    always_comb begin
        lk_bit_d = sda_in;
        lk_tog_d = ~lk_tog_q;
    end
    always_ff @(posedge serial_clk) begin
        lk_bit_q <= lk_bit_d;
        lk_tog_q <= lk_tog_d;
    end

    // ----------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ----------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] s1_q, s2_q, s3_q, f_q, fp_q;
    logic [5:0] f_d;
    assign pin_raw = {lk_tog_q, module_reset_n, low_power_select,
        module_select_n, sda_in, serial_clk};
    always_comb begin
        f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
            s3_q <= PIN_IDLE;
            f_q <= PIN_IDLE;
            fp_q <= PIN_IDLE;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
            fp_q <= f_q;
        end
    end

    // bus events seen in the core domain
    logic sel, scl_fall, bus_start, bus_stop, bit_evt;
    assign sel = ~f_q[PIN_SEL];
    assign scl_fall = fp_q[PIN_SCL] & ~f_q[PIN_SCL];
    assign bus_start = f_q[PIN_SCL] & fp_q[PIN_SCL] & fp_q[PIN_SDA]
        & ~f_q[PIN_SDA];
    assign bus_stop = f_q[PIN_SCL] & fp_q[PIN_SCL] & ~fp_q[PIN_SDA]
        & f_q[PIN_SDA];
    assign bit_evt = f_q[PIN_TOG] ^ fp_q[PIN_TOG];

    // ----------------------------------------------------------------
    // module reset and power-up sequencing
    // ----------------------------------------------------------------
    pmm_mode_t md_q, md_d;
    logic [9:0] tmr_q, tmr_d;
    logic done_evt;
    always_comb begin
        md_d = md_q;
        tmr_d = 10'h000;
        done_evt = 1'b0;
        case (md_q)
            MD_INIT: begin
                // power-up completes on its own, no reset pulse needed
                tmr_d = tmr_q + 10'h001;
                if (tmr_q == 10'(INIT_CYC - 1)) begin
                    md_d = MD_RUN;
                    done_evt = 1'b1;
                end
            end
            MD_RST: begin
                if (f_q[PIN_RST]) begin
                    md_d = MD_INIT;
                end
            end
            MD_RUN: begin
                // shorter low pulses are glitches and are ignored
                if (!f_q[PIN_RST]) begin
                    tmr_d = tmr_q + 10'h001;
                    if (tmr_q == 10'(RST_MIN_CYC - 1)) begin
                        md_d = MD_RST;
                    end
                end
            end
            default: md_d = MD_INIT;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            md_q <= MD_INIT;
            tmr_q <= 10'h000;
        end else begin
            md_q <= md_d;
            tmr_q <= tmr_d;
        end
    end

    // ----------------------------------------------------------------
    // serial slave and memory map
    // ----------------------------------------------------------------
    pmm_ps_t ps_q, ps_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, nb, rd_val;
    logic [2:0] ptr_q, ptr_d;
    logic [1:0] ph_q, ph_d;
    logic rw_q, rw_d, drv_q, drv_d, hk_q, hk_d, ld;
    logic [7:0] mem_q [8];
    logic [7:0] mem_d [8];
    logic [7:0] flag_q, flag_d;

    // bytes that software may write; the rest are read-only
    function automatic logic is_rw(input logic [2:0] idx);
        is_rw = (idx == IDX_CHAN) || (idx[2] == 1'b1);
    endfunction

    // read view: live status beside stored bytes
    always_comb begin
        case (ptr_q)
            IDX_STATUS: begin
                rd_val = 8'h00;
                rd_val[ST_DNR_BIT] = (md_q != MD_RUN);
                rd_val[ST_LP_BIT] = f_q[PIN_LP];
            end
            IDX_FLAGS: rd_val = flag_q;
            IDX_FAULT: rd_val = {4'h0, chan_fault};
            default: rd_val = mem_q[ptr_q];
        endcase
    end

    always_comb begin
        ps_d = ps_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        ph_d = ph_q;
        rw_d = rw_q;
        drv_d = drv_q;
        hk_d = hk_q;
        mem_d = mem_q;
        ld = 1'b0;
        nb = {sh_q[6:0], lk_bit_q};
        if (!sel || bus_stop) begin
            ps_d = PS_IDLE;
            drv_d = 1'b0;
        end else if (bus_start) begin
            ps_d = PS_RX;
            cnt_d = 4'h0;
            ph_d = PH_ADDR;
            drv_d = 1'b0;
        end else begin
            case (ps_q)
                PS_IDLE: drv_d = 1'b0;
                PS_RX: begin
                    if (bit_evt) begin
                        sh_d = nb;
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            cnt_d = 4'h0;
                            hk_d = 1'b0;
                            ps_d = PS_ACK;
                            ph_d = (ph_q == PH_ADDR) ? PH_PTR : PH_DATA;
                            if (ph_q == PH_ADDR) begin
                                rw_d = nb[0];
                                // other addresses are left alone
                                if (nb[7:1] != DEV_ADDR) begin
                                    ps_d = PS_IDLE;
                                end
                            end else if (ph_q == PH_PTR) begin
                                ptr_d = nb[2:0];
                            end else begin
                                if (is_rw(ptr_q)) begin
                                    mem_d[ptr_q] = nb;
                                end
                                ptr_d = ptr_q + 3'h1;
                            end
                        end
                    end
                end
                PS_ACK: begin
                    // hold ack low across the ninth clock
                    if (scl_fall) begin
                        if (!hk_q) begin
                            drv_d = 1'b1;
                            hk_d = 1'b1;
                        end else if (rw_q) begin
                            ld = 1'b1;
                        end else begin
                            drv_d = 1'b0;
                            ps_d = PS_RX;
                        end
                    end
                end
                PS_TX: begin
                    if (bit_evt) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            drv_d = 1'b0;
                            hk_d = 1'b0;
                            ps_d = PS_HACK;
                        end else begin
                            drv_d = ~sh_q[6];
                            sh_d = {sh_q[6:0], 1'b0};
                        end
                    end
                end
                PS_HACK: begin
                    if (bit_evt) begin
                        hk_d = ~lk_bit_q;
                    end
                    if (scl_fall) begin
                        ld = hk_q;
                        if (!hk_q) begin
                            ps_d = PS_IDLE;
                        end
                    end
                end
                default: ps_d = PS_IDLE;
            endcase
        end
        if (ld) begin
            sh_d = rd_val;
            ptr_d = ptr_q + 3'h1;
            drv_d = ~rd_val[7];
            cnt_d = 4'h0;
            ps_d = PS_TX;
        end
        // sticky flags: a new event wins over the clear-on-read
        flag_d = (ld && ptr_q == IDX_FLAGS) ? 8'h00 : flag_q;
        flag_d = flag_d | {chan_fault, 3'h0, done_evt};
        if (md_q == MD_RST) begin
            // full reset: every setting back to default
            for (int i = 0; i < 8; i++) begin
                mem_d[i] = 8'h00;
            end
            flag_d = 8'h00;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ps_q <= PS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 3'h0;
            ph_q <= PH_ADDR;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            hk_q <= 1'b0;
            flag_q <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            ps_q <= ps_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            ph_q <= ph_d;
            rw_q <= rw_d;
            drv_q <= drv_d;
            hk_q <= hk_d;
            flag_q <= flag_d;
            mem_q <= mem_d;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    logic int_q, prs_q, lp_q;
    logic [3:0] txd_q;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_q <= 1'b0;
            prs_q <= 1'b0;
            lp_q <= 1'b0;
            txd_q <= 4'h0;
        end else begin
            int_q <= |flag_d;
            prs_q <= 1'b1;
            lp_q <= f_q[PIN_LP];
            txd_q <= mem_d[IDX_CHAN][3:0];
        end
    end
    // open-drain lines only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = drv_q;
    assign interrupt_n_out = 1'b0;
    assign interrupt_n_oe = int_q;
    assign module_present_n_out = 1'b0;
    assign module_present_n_oe = prs_q;
    assign tx_disable = txd_q;
    assign power_limit = lp_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_desel_release: assert property (
        !sel |=> !sda_oe && ps_q == PS_IDLE)
        else $error("sda driven while deselected");
    a_desel_no_store: assert property (
        !sel && !$past(sel) && md_q == MD_RUN |=> $stable(mem_q[IDX_CHAN]))
        else $error("deselected write changed memory");
    a_present_low: assert property (
        $past(!srst) |-> module_present_n_oe && !module_present_n_out)
        else $error("presence line not pulled low");
    a_int_flags: assert property (
        ##1 interrupt_n_oe == |flag_q && !interrupt_n_out)
        else $error("interrupt does not follow flags");
    // a fault pin must reach the interrupt line within one cycle
    a_fault_int: assert property (
        |chan_fault && md_q != MD_RST |=> interrupt_n_oe)
        else $error("channel fault raised no interrupt");
    a_reset_default: assert property (
        md_q == MD_RST |=> txd_q == 4'h0 && flag_q == 8'h00)
        else $error("reset left settings");
    a_reset_done: assert property (
        md_q == MD_INIT && md_d == MD_RUN |=> flag_q[FL_DONE_BIT]
        ##1 interrupt_n_oe)
        else $error("no completion interrupt");
    a_powerup_int: assert property (
        $fell(srst) |-> ##[48:52] flag_q[FL_DONE_BIT])
        else $error("no power-up interrupt");
    a_low_power: assert property (
        f_q[PIN_LP] [*2] |-> power_limit)
        else $error("low power not applied");
    a_chan_disable: assert property (
        ##1 tx_disable == mem_q[IDX_CHAN][3:0])
        else $error("channel disable mismatch");
    // a pulse that ends on its last counted cycle is long, not a glitch
    a_short_glitch: assert property (
        md_q == MD_RUN && !f_q[PIN_RST] && f_d[PIN_RST]
        && tmr_q != 10'(RST_MIN_CYC - 1) |=> md_q == MD_RUN)
        else $error("short reset pulse acted");
    c_module_reset: cover property (md_q == MD_RST ##[1:1000] md_q == MD_RUN);
    c_read_byte: cover property (ps_q == PS_TX ##1 ps_q == PS_HACK);
    c_write_byte: cover property (ps_q == PS_RX && ph_q == PH_DATA
        && bit_evt && cnt_q == 4'h7);
    c_deselect: cover property (ps_q == PS_RX && !sel);
    c_read_burst: cover property (ps_q == PS_HACK && hk_q ##1 ps_q == PS_TX);
endmodule

// ==== pmm_host_model.sv ====
// host controller model that masters the shared two-wire bus
`timescale 1ns/1ps
module pmm_host_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    // 14 ticks of 15 ns keep each clock phase past the 200 ns minimum
    localparam int HALF = 14;
    logic lk_clk = 1'b0;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // tick base only; scl stands still between frames
    always #7.5 lk_clk = ~lk_clk;
    task automatic ph();
        repeat (HALF) @(posedge lk_clk);
    endtask
    // data moves a few ticks after scl falls so no false start or stop
    task automatic xfer(input logic b, output logic s);
        repeat (3) @(posedge lk_clk);
        sda_drv = b;
        ph();
        scl = 1'b1;
        ph();
        s = sda_line;
        scl = 1'b0;
    endtask
    // start, also used as repeated start
    task automatic start();
        repeat (3) @(posedge lk_clk);
        sda_drv = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_drv = 1'b0;
        ph();
        scl = 1'b0;
    endtask
    task automatic stop();
        repeat (3) @(posedge lk_clk);
        sda_drv = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_drv = 1'b1;
        ph();
    endtask
    // bytes go msb first, the ninth clock carries the acknowledge
    task automatic send(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, ack_n);
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, s);
    endtask
endmodule

// ==== pluggable_module_mgmt_control_test.sv ====
// self-checking bench of the module management block
`timescale 1ns/1ps
module pluggable_module_mgmt_control_test;
    import pmm_pkg::*;
    logic core_clk, srst, module_select_n, module_reset_n, low_power_select;
    logic [3:0] chan_fault, tx_disable, last_dis;
    logic scl, sda_drv, sda_out, sda_oe, prs_out, prs_oe, irq_out, irq_oe;
    logic power_limit, nk;
    logic [2:0] p;
    logic [7:0] d, d2;
    logic [31:0] rnd_q = 32'hb5ff919f;
    int error_cnt = 0;
    int samples_checked = 0;
    // open-drain wires with the host pull-ups
    wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
    wire prs_line = ~(prs_oe & ~prs_out);
    wire irq_line = ~(irq_oe & ~irq_out);
    // seven control lines reach the module
    pmm_ctrl u_dut (
        .core_clk(core_clk), .srst(srst), .serial_clk(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .module_select_n(module_select_n), .module_reset_n(module_reset_n),
        .low_power_select(low_power_select),
        .module_present_n_out(prs_out), .module_present_n_oe(prs_oe),
        .interrupt_n_out(irq_out), .interrupt_n_oe(irq_oe),
        .chan_fault(chan_fault), .tx_disable(tx_disable),
        .power_limit(power_limit));
    pmm_host_model u_host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [7:0] exp_status(input logic nr, lp);
        return {6'h00, lp, nr};
    endfunction
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d0, d1,
        input int n, output logic ack_n);
        logic x;
        u_host.start();
        u_host.send({DEV_ADDR, 1'b0}, ack_n);
        u_host.send({5'h00, a}, x);
        u_host.send(d0, x);
        if (n > 1) u_host.send(d1, x);
        u_host.stop();
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        logic x;
        u_host.start();
        u_host.send({DEV_ADDR, 1'b0}, x);
        u_host.send({5'h00, a}, x);
        u_host.start();
        u_host.send({DEV_ADDR, 1'b1}, x);
        u_host.recv(1'b1, v);
        u_host.stop();
    endtask
    // two bytes in one read: the host acks the first so the pointer runs on
    task automatic rd_pair(input logic [2:0] a, output logic [7:0] v0, v1);
        logic x;
        u_host.start();
        u_host.send({DEV_ADDR, 1'b0}, x);
        u_host.send({5'h00, a}, x);
        u_host.start();
        u_host.send({DEV_ADDR, 1'b1}, x);
        u_host.recv(1'b0, v0);
        u_host.recv(1'b1, v1);
        u_host.stop();
    endtask
    // bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic lvl);
        int k;
        k = 0;
        while (irq_line !== lvl && k < 100) begin
            @(posedge core_clk);
            k++;
        end
        if (irq_line !== lvl) begin
            error_cnt++;
            end_sim();
        end
    endtask
    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        srst = 1'b1;
        module_select_n = 1'b1;
        module_reset_n = 1'b1;
        low_power_select = 1'b0;
        chan_fault = 4'h0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        module_select_n <= 1'b0;
        repeat (40) @(posedge core_clk);
        chk("int_early", 8'h01, irq_line);
        chk("present", 8'h00, prs_line);
        wait_irq(1'b0);
        rd(IDX_STATUS, d);
        chk("status", exp_status(1'b0, 1'b0), d);
        rd(IDX_FLAGS, d);
        chk("flags", 8'h01, d);
        chk("int_clear", 8'h01, irq_line);
        // random traffic: channel disables, scratch pairs, faults
        for (int i = 0; i < 6; i++) begin
            rnd_q = xs(rnd_q);
            p = {1'b1, rnd_q[0], 1'b0};
            @(posedge core_clk);
            low_power_select <= rnd_q[1];
            wr(IDX_CHAN, {4'h0, rnd_q[7:4]}, 8'h00, 1, nk);
            chk("ack", 8'h00, nk);
            chk("tx_disable", rnd_q[7:4], tx_disable);
            last_dis = rnd_q[7:4];
            wr(p, rnd_q[15:8], rnd_q[23:16], 2, nk);
            rd_pair(p, d, d2);
            chk("byte0", rnd_q[15:8], d);
            chk("byte1", rnd_q[23:16], d2);
            chk("power_limit", rnd_q[1], power_limit);
            rd(IDX_STATUS, d);
            chk("status", exp_status(1'b0, rnd_q[1]), d);
            @(posedge core_clk);
            chan_fault <= rnd_q[27:24];
            // fault byte shows the live pins while they are held
            rd(IDX_FAULT, d);
            chk("fault", {4'h0, rnd_q[27:24]}, d);
            @(posedge core_clk);
            chan_fault <= 4'h0;
            repeat (3) @(posedge core_clk);
            chk("int", {7'h00, rnd_q[27:24] == 4'h0}, irq_line);
            rd(IDX_FLAGS, d);
            chk("flags", {rnd_q[27:24], 4'h0}, d);
        end
        // deselected module must ignore a write aimed at its address
        wr(3'h4, 8'hc3, 8'h00, 1, nk);
        @(posedge core_clk);
        module_select_n <= 1'b1;
        low_power_select <= 1'b0;
        repeat (5) @(posedge core_clk);
        wr(3'h4, 8'h5a, 8'h00, 1, nk);
        chk("nack", 8'h01, nk);
        @(posedge core_clk);
        module_select_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(3'h4, d);
        chk("kept", 8'hc3, d);
        // a short reset pulse is filtered out
        module_reset_n <= 1'b0;
        repeat (100) @(posedge core_clk);
        module_reset_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk("short_rst", last_dis, tx_disable);
        // a long pulse restores defaults; status is not read meanwhile
        module_reset_n <= 1'b0;
        repeat (520) @(posedge core_clk);
        chk("rst_dis", 8'h00, tx_disable);
        chk("rst_int", 8'h01, irq_line);
        module_reset_n <= 1'b1;
        wait_irq(1'b0);
        rd(IDX_STATUS, d);
        chk("status", exp_status(1'b0, 1'b0), d);
        rd(3'h4, d);
        chk("scratch", 8'h00, d);
        end_sim();
    end
endmodule
